// >>> cscsr_pkg.sv
// Purpose: shared constants and types for the crt scan, cursor and start address block
// Assumes: byte wide indexed register port, one clock domain
// Notes: offsets are indices on the crt data port
package cscsr_pkg;

  // register indices
  localparam logic [7:0] CSCSR_IDX_MAX_SCAN   = 8'h09;
  localparam logic [7:0] CSCSR_IDX_CUR_START  = 8'h0a;
  localparam logic [7:0] CSCSR_IDX_CUR_END    = 8'h0b;
  localparam logic [7:0] CSCSR_IDX_START_HIGH = 8'h0c;

  // reset values
  localparam logic [7:0] CSCSR_RST_MAX_SCAN   = 8'h00;
  localparam logic [7:0] CSCSR_RST_CUR_START  = 8'h00;
  localparam logic [7:0] CSCSR_RST_CUR_END    = 8'h00;
  localparam logic [7:0] CSCSR_RST_START_HIGH = 8'h00;

  // writable bit masks, reserved bits read as zero
  localparam logic [7:0] CSCSR_MASK_CUR_START = 8'h3f;
  localparam logic [7:0] CSCSR_MASK_CUR_END   = 8'h7f;

  // field positions
  localparam int CSCSR_DBL_SCAN_BIT  = 7;
  localparam int CSCSR_LCMP9_BIT     = 6;
  localparam int CSCSR_VBS9_BIT      = 5;
  localparam int CSCSR_CUR_OFF_BIT   = 5;
  localparam int CSCSR_SKEW_LSB      = 5;
  localparam int CSCSR_OVF_LCMP8_BIT = 4;
  localparam int CSCSR_OVF_VBS8_BIT  = 3;
  localparam int CSCSR_EXT_REQ_BIT   = 7;
  localparam int CSCSR_MODE_EXT_BIT  = 0;

  // timing figures
  localparam int CSCSR_ROW_W     = 5;
  localparam int CSCSR_LINE_W    = 12;
  localparam int CSCSR_MAX_SKEW  = 3;

  typedef struct packed {
    logic [7:0] start_high;
    logic [7:0] cur_end;
    logic [7:0] cur_start;
    logic [7:0] max_scan;
  } cscsr_regs_t;

  typedef struct packed {
    logic line;
    logic vsync;
    logic char_clk;
  } cscsr_timing_t;

  typedef struct packed {
    logic [7:0] ovf;
    logic [7:0] vbs_low;
    logic [7:0] vbs_ext;
    logic [7:0] cmp_low;
    logic [7:0] start_low;
    logic [7:0] ext_mid;
    logic [7:0] ext_top;
    logic [7:0] mode;
  } cscsr_ext_regs_t;

  typedef enum logic {
    CSCSR_PASS_FIRST  = 1'b0,
    CSCSR_PASS_REPEAT = 1'b1
  } cscsr_pass_t;

endpackage : cscsr_pkg

// >>> cscsr_row_scan.sv
// Purpose: row scan counter with double scan
// Assumes: line pulse once per horizontal scan line
// Notes: frame pulse restarts the count at row zero
`timescale 1ns/1ps
module cscsr_row_scan #(
  parameter int ROW_W = 5
) (
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             line_in,
  input  wire logic             frame_in,
  input  wire logic             dbl_in,
  input  wire logic [ROW_W-1:0] max_row_in,
  output logic      [ROW_W-1:0] row_out,
  output logic                  wrap_out
);
  cscsr_pkg::cscsr_pass_t pass_q;
  cscsr_pkg::cscsr_pass_t pass_d;
  logic [ROW_W-1:0] row_d;
  logic             adv;
  logic             at_max;

  initial begin
    if (ROW_W < 1) $error("row width must be positive");
  end

  // first pass of a doubled line holds the count
  always_comb begin
    case (pass_q)
      cscsr_pkg::CSCSR_PASS_FIRST:  adv = !dbl_in;
      cscsr_pkg::CSCSR_PASS_REPEAT: adv = 1'b1;
      default:                      adv = 1'b1;
    endcase
  end
  assign pass_d = (dbl_in && pass_q == cscsr_pkg::CSCSR_PASS_FIRST) ?
                  cscsr_pkg::CSCSR_PASS_REPEAT : cscsr_pkg::CSCSR_PASS_FIRST;
  assign at_max = (row_out == max_row_in);
  assign row_d  = at_max ? '0 : row_out + 1'b1;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pass_q   <= cscsr_pkg::CSCSR_PASS_FIRST;
      row_out  <= '0;
      wrap_out <= 1'b0;
    end else if (ce_in) begin
      wrap_out <= 1'b0;
      if (frame_in) begin
        pass_q  <= cscsr_pkg::CSCSR_PASS_FIRST;
        row_out <= '0;
      end else if (line_in) begin
        pass_q <= pass_d;
        if (adv) begin
          row_out  <= row_d;
          wrap_out <= at_max;
        end
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_single_scan_step: assert property ((ce_in && line_in && !frame_in && !dbl_in &&
      !at_max) |=> row_out == $past(row_out) + 1'b1)
    else $error("row did not advance on a single scanned line");
  a_double_scan_hold: assert property ((ce_in && line_in && !frame_in && dbl_in &&
      pass_q == cscsr_pkg::CSCSR_PASS_FIRST) |=> $stable(row_out))
    else $error("row advanced on the first pass of a doubled line");
  a_row_wraps_max: assert property ((ce_in && line_in && !frame_in && adv && at_max)
      |=> row_out == '0 && wrap_out)
    else $error("row did not wrap after the programmed height");
  c_double_scan: cover property ((dbl_in && line_in) ##[1:8] line_in);
endmodule : cscsr_row_scan

// >>> cscsr_cursor_skew.sv
// Purpose: text cursor skew delay, cursor shaping is done in cscsr_top
// Assumes: char_clk_in pulses once per character clock
// Notes: delay line stages advance only on character clocks
`timescale 1ns/1ps
module cscsr_cursor_skew #(
  parameter int MAX_SKEW = 3
) (
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  input  wire logic       char_clk_in,
  input  wire logic       cur_raw_in,
  input  wire logic [1:0] skew_in,
  output logic            cursor_out
);
  logic [MAX_SKEW:0] tap;
  logic [MAX_SKEW:1] dly_q;

  initial begin
    if (MAX_SKEW != 3) $error("skew field is two bits, max skew must be 3");
  end

  assign tap[0] = cur_raw_in;
  genvar g;
  generate
    for (g = 1; g <= MAX_SKEW; g++) begin : g_stage
      assign tap[g] = dly_q[g];
      always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
          dly_q[g] <= 1'b0;
        end else if (ce_in && char_clk_in) begin
          dly_q[g] <= tap[g-1];
        end
      end
    end
  endgenerate

  // selected tap registered so the output stays a flop
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cursor_out <= 1'b0;
    end else if (ce_in) begin
      cursor_out <= tap[skew_in];
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_skew_zero_pass: assert property ((ce_in && skew_in == 2'h0) |=> cursor_out == $past(cur_raw_in))
    else $error("zero skew cursor not passed through");
  a_skew_one_delay: assert property ((ce_in && char_clk_in && skew_in == 2'h1) ##1
      (ce_in && skew_in == 2'h1) |=> cursor_out == $past(cur_raw_in, 2))
    else $error("one clock skew not applied");
endmodule : cscsr_cursor_skew

// >>> cscsr_top.sv
// Purpose: crt row scan, split line, blanking start, text cursor and start address
// Assumes: line, vsync and char clock are one cycle strobes synchronous to clock_in
// Notes: other crt registers arrive as plain inputs
//
// Functional notes
// - single scan advances row every line
// - double scan advances row every second line
// - compare line is ten bits, three sources
// - compare line restarts memory address at zero
// - standard blanking start is ten bits
// - extended blanking start is twelve bits
// - blanking starts on line equal to start
// - text cursor only in text modes
// - cursor off bit suppresses the cursor
// - cursor begins on start line
// - cursor ends on end line
// - skew delays cursor zero to three clocks
// - standard start offset is sixteen bits
// - extended start address is thirty two bits
// - extended start loads at vsync, request cleared
// - registers reached by index on data port
// - standard blanking bit eight from overflow
`timescale 1ns/1ps
module cscsr_top #(
  parameter int ROW_W    = cscsr_pkg::CSCSR_ROW_W,
  parameter int LINE_W   = cscsr_pkg::CSCSR_LINE_W,
  parameter int MAX_SKEW = cscsr_pkg::CSCSR_MAX_SKEW
) (
  input  wire logic                       clock_in,
  input  wire logic                       rst_in,
  input  wire logic                       ce_in,
  input  wire logic                       reg_wr_in,
  input  wire logic                       reg_rd_in,
  input  wire logic [7:0]                 reg_index_in,
  input  wire logic [7:0]                 reg_wdata_in,
  input  wire cscsr_pkg::cscsr_timing_t   timing_in,
  input  wire cscsr_pkg::cscsr_ext_regs_t ext_regs_in,
  input  wire logic                       text_mode_in,
  input  wire logic                       cursor_hit_in,
  input  wire logic [7:0]                 row_offset_in,
  output logic [7:0]                      reg_rdata_out,
  output logic [ROW_W-1:0]                row_scan_out,
  output logic [LINE_W-1:0]               line_out,
  output logic                            vblank_out,
  output logic                            split_out,
  output logic [31:0]                     start_addr_out,
  output logic [31:0]                     mem_addr_out,
  output logic                            ext_req_clear_out,
  output logic                            cursor_out
);
  cscsr_pkg::cscsr_regs_t regs_q;
  cscsr_pkg::cscsr_regs_t regs_d;

  logic [7:0]        rdata_d;
  logic              wr_en;
  logic              rd_en;
  logic              ext_mode;
  logic              dbl_scan;
  logic [ROW_W-1:0]  max_row;
  logic              row_wrap;
  logic [9:0]        cmp_line;
  logic [11:0]       vbs_std;
  logic [11:0]       vbs_ext;
  logic [11:0]       vbs_line;
  logic [LINE_W-1:0] line_d;
  logic              vbs_hit;
  logic              cmp_hit;
  logic [31:0]       std_start;
  logic [31:0]       ext_start;
  logic              ext_req;
  logic              ext_load;
  logic [31:0]       start_d;
  logic [31:0]       mem_d;
  logic [4:0]        cur_first;
  logic [4:0]        cur_last;
  logic              cur_off;
  logic              cur_rows;
  logic              cur_raw;
  logic [1:0]        cur_skew;
  logic              split_d;

  initial begin
    if (LINE_W < 12) $error("line counter must hold a twelve bit blanking start");
    if (ROW_W != 5) $error("row field is five bits");
  end

  function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] target);
    return idx == target;
  endfunction : idx_is

  // register port
  assign wr_en = ce_in && reg_wr_in;
  assign rd_en = ce_in && reg_rd_in;

  always_comb begin
    regs_d = regs_q;
    if (wr_en) begin
      if (idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_MAX_SCAN)) begin
        regs_d.max_scan = reg_wdata_in;
      end
      if (idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_CUR_START)) begin
        regs_d.cur_start = reg_wdata_in & cscsr_pkg::CSCSR_MASK_CUR_START;
      end
      if (idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_CUR_END)) begin
        regs_d.cur_end = reg_wdata_in & cscsr_pkg::CSCSR_MASK_CUR_END;
      end
      if (idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_START_HIGH)) begin
        regs_d.start_high = reg_wdata_in;
      end
    end
  end

  // unmapped indices read zero, other crt registers answer elsewhere
  assign rdata_d =
    idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_MAX_SCAN)   ? regs_q.max_scan   :
    idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_CUR_START)  ? regs_q.cur_start  :
    idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_CUR_END)    ? regs_q.cur_end    :
    idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_START_HIGH) ? regs_q.start_high :
    8'h00;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      regs_q <= '{start_high: cscsr_pkg::CSCSR_RST_START_HIGH,
                  cur_end:    cscsr_pkg::CSCSR_RST_CUR_END,
                  cur_start:  cscsr_pkg::CSCSR_RST_CUR_START,
                  max_scan:   cscsr_pkg::CSCSR_RST_MAX_SCAN};
      reg_rdata_out <= 8'h00;
    end else begin
      regs_q <= regs_d;
      if (rd_en) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

  // field decode
  assign ext_mode = ext_regs_in.mode[cscsr_pkg::CSCSR_MODE_EXT_BIT];
  assign dbl_scan = regs_q.max_scan[cscsr_pkg::CSCSR_DBL_SCAN_BIT];
  assign max_row  = regs_q.max_scan[ROW_W-1:0];

  assign cmp_line = {regs_q.max_scan[cscsr_pkg::CSCSR_LCMP9_BIT],
                     ext_regs_in.ovf[cscsr_pkg::CSCSR_OVF_LCMP8_BIT],
                     ext_regs_in.cmp_low};

  assign vbs_std  = {2'h0, regs_q.max_scan[cscsr_pkg::CSCSR_VBS9_BIT],
                     ext_regs_in.ovf[cscsr_pkg::CSCSR_OVF_VBS8_BIT],
                     ext_regs_in.vbs_low};
  // high standard bits dropped in extended mode
  assign vbs_ext  = {ext_regs_in.vbs_ext[3:0], ext_regs_in.vbs_low};
  assign vbs_line = ext_mode ? vbs_ext : vbs_std;

  // row scan counter
  cscsr_row_scan #(
    .ROW_W(ROW_W)
  ) u_row (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .line_in    (timing_in.line),
    .frame_in   (timing_in.vsync),
    .dbl_in     (dbl_scan),
    .max_row_in (max_row),
    .row_out    (row_scan_out),
    .wrap_out   (row_wrap)
  );

  // vertical line counter, line zero is the first active line
  assign line_d  = timing_in.vsync ? '0 : line_out + 1'b1;
  assign vbs_hit = (line_d == LINE_W'(vbs_line));
  assign cmp_hit = (line_d == LINE_W'(cmp_line));

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      line_out   <= '0;
      vblank_out <= 1'b0;
    end else if (ce_in && (timing_in.line || timing_in.vsync)) begin
      line_out   <= line_d;
      vblank_out <= timing_in.vsync ? 1'b0 : (vblank_out || vbs_hit);
    end
  end

  // start address
  assign std_start = {16'h0000, regs_q.start_high, ext_regs_in.start_low};
  assign ext_start = {ext_regs_in.ext_top, ext_regs_in.ext_mid[5:0],
                      regs_q.start_high, ext_regs_in.start_low, 2'b00};
  assign ext_req   = ext_regs_in.ext_mid[cscsr_pkg::CSCSR_EXT_REQ_BIT];
  // request after the four address writes is relied on, no staging of the parts
  assign ext_load  = ext_mode && ext_req && timing_in.vsync && !ext_req_clear_out;
  // extended address held until the vsync load
  assign start_d   = !ext_mode ? std_start :
                     ext_load  ? ext_start : start_addr_out;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      start_addr_out    <= 32'h0000_0000;
      ext_req_clear_out <= 1'b0;
    end else if (ce_in) begin
      start_addr_out    <= start_d;
      ext_req_clear_out <= ext_load;
    end
  end

  // memory address: new frame base, row step, split restart at zero
  assign split_d = timing_in.vsync ? 1'b0 : (split_out || cmp_hit);
  always_comb begin
    mem_d = mem_addr_out;
    if (timing_in.vsync) begin
      mem_d = start_d;
    end else if (timing_in.line && cmp_hit) begin
      mem_d = 32'h0000_0000;
    end else if (row_wrap) begin
      mem_d = mem_addr_out + {24'h000000, row_offset_in};
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mem_addr_out <= 32'h0000_0000;
      split_out    <= 1'b0;
    end else if (ce_in) begin
      mem_addr_out <= mem_d;
      if (timing_in.line || timing_in.vsync) begin
        split_out <= split_d;
      end
    end
  end

  // text cursor shape
  assign cur_first = regs_q.cur_start[4:0];
  assign cur_last  = regs_q.cur_end[4:0];
  assign cur_off   = regs_q.cur_start[cscsr_pkg::CSCSR_CUR_OFF_BIT];
  assign cur_skew  = regs_q.cur_end[cscsr_pkg::CSCSR_SKEW_LSB +: 2];
  assign cur_rows  = (row_scan_out >= cur_first) && (row_scan_out <= cur_last);
  // graphics modes force the raw cursor off, the cur_end skew field still selects the delay tap
  assign cur_raw   = text_mode_in && !cur_off && cur_rows && cursor_hit_in;

  cscsr_cursor_skew #(
    .MAX_SKEW(MAX_SKEW)
  ) u_cursor (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .char_clk_in (timing_in.char_clk),
    .cur_raw_in  (cur_raw),
    .skew_in     (cur_skew),
    .cursor_out  (cursor_out)
  );

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_compare_restart: assert property ((ce_in && timing_in.line && !timing_in.vsync &&
      line_d == LINE_W'(cmp_line)) |=> mem_addr_out == 32'h0000_0000 && split_out)
    else $error("memory address not restarted at compare line");
  a_vblank_begin_std: assert property ((ce_in && timing_in.line && !timing_in.vsync &&
      !ext_mode && !vblank_out && line_d == LINE_W'(vbs_std)) |=> vblank_out)
    else $error("standard blanking start missed");
  a_vblank_begin_ext: assert property ((ce_in && timing_in.line && !timing_in.vsync &&
      ext_mode && !vblank_out && line_d == LINE_W'(vbs_ext)) |=> vblank_out)
    else $error("extended blanking start missed");
  a_vblank_not_early: assert property ((ce_in && timing_in.vsync) ##1
      (!vblank_out throughout (line_out < LINE_W'(vbs_line))[*2]) |-> !vblank_out)
    else $error("blanking began before start line");
  a_std_start_word: assert property ((ce_in && !ext_mode) |=>
      start_addr_out == {16'h0000, $past(regs_q.start_high), $past(ext_regs_in.start_low)})
    else $error("standard start offset wrong");
  a_ext_start_load: assert property (ext_load && ce_in |=>
      start_addr_out[1:0] == 2'b00 && ext_req_clear_out &&
      start_addr_out[31:24] == $past(ext_regs_in.ext_top))
    else $error("extended start not loaded at vsync");
  a_ext_start_hold: assert property ((ce_in && ext_mode && !ext_load) |=> $stable(start_addr_out))
    else $error("extended start changed without vsync load");
  a_cursor_gfx_off: assert property (!text_mode_in |-> !cur_raw)
    else $error("cursor drawn in graphics mode");
  a_cursor_off_bit: assert property (cur_off |-> !cur_raw)
    else $error("cursor drawn while disabled");
  a_cursor_rows: assert property ((text_mode_in && !cur_off && cursor_hit_in &&
      row_scan_out == cur_first && cur_first <= cur_last) |-> cur_raw)
    else $error("cursor missing on its start line");
  a_reg_readback: assert property ((wr_en && idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_START_HIGH))
      ##1 (rd_en && !wr_en && idx_is(reg_index_in, cscsr_pkg::CSCSR_IDX_START_HIGH))
      |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("start high readback mismatch");
  a_split_cmp_line: assert property ((ce_in && timing_in.line && !timing_in.vsync &&
      line_d == LINE_W'({regs_q.max_scan[6], ext_regs_in.ovf[4], ext_regs_in.cmp_low}))
      |=> split_out)
    else $error("compare line composed wrongly");

  c_split_screen: cover property (timing_in.vsync ##[1:1000] split_out);
  c_ext_update:   cover property (ext_load ##1 ext_req_clear_out);
  c_cursor_shown: cover property (cursor_out && cur_skew == 2'h3);
endmodule : cscsr_top

// >>> cscsr_bench.sv
// Purpose: self-checking bench for the crt scan, cursor and start address block
// Assumes: inputs change at the falling edge, strobes are one cycle wide
// Notes: ce held high except in one test_rows check, row step held at zero so the row base only moves at vsync and split
`timescale 1ns/1ps
module cscsr_bench;
  logic                       clock_in = 1'b0;
  logic                       rst_in = 1'b1;
  logic                       ce = 1'b1;
  logic                       wr = 1'b0;
  logic                       rd = 1'b0;
  logic [7:0]                 idx = 8'h00;
  logic [7:0]                 wdat = 8'h00;
  cscsr_pkg::cscsr_timing_t   tim = '0;
  cscsr_pkg::cscsr_ext_regs_t ext = '0;
  logic                       text = 1'b1;
  logic                       hit = 1'b1;
  logic [7:0]                 rdata;
  logic [4:0]                 row;
  logic [11:0]                line;
  logic                       vblank, split, req_clr, cursor;
  logic [31:0]                start, mem;
  int                         n_mismatch = 0;
  int                         n_compared = 0;

  always #20 clock_in = ~clock_in;

  cscsr_top dut (
    .clock_in(clock_in), .rst_in(rst_in), .ce_in(ce), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_index_in(idx), .reg_wdata_in(wdat), .timing_in(tim), .ext_regs_in(ext),
    .text_mode_in(text), .cursor_hit_in(hit), .row_offset_in(8'h00),
    .reg_rdata_out(rdata), .row_scan_out(row), .line_out(line), .vblank_out(vblank),
    .split_out(split), .start_addr_out(start), .mem_addr_out(mem),
    .ext_req_clear_out(req_clr), .cursor_out(cursor)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
    @(negedge clock_in);
    wr = 1'b1;
    idx = i;
    wdat = d;
    @(negedge clock_in);
    wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] i, output logic [7:0] d);
    @(negedge clock_in);
    rd = 1'b1;
    idx = i;
    @(negedge clock_in);
    rd = 1'b0;
    @(negedge clock_in);
    d = rdata;
  endtask : rd_reg

  // code is {line, vsync, char_clk}; extra cycles let registered outputs settle
  task automatic pulse(input logic [2:0] code);
    @(negedge clock_in);
    tim = cscsr_pkg::cscsr_timing_t'(code);
    @(negedge clock_in);
    tim = '0;
    repeat (2) @(negedge clock_in);
  endtask : pulse

  task automatic test_regs();
    logic [7:0] v;
    logic [7:0] ix [5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
    logic [7:0] mk [5] = '{8'hff, 8'h3f, 8'h7f, 8'hff, 8'h00};
    for (int k = 0; k < 5; k++) begin
      rd_reg(ix[k], v);
      check(v, 8'h00);
      wr_reg(ix[k], 8'hff);
      rd_reg(ix[k], v);
      check(v, mk[k]);
    end
    $display("test regs done");
  endtask : test_regs

  task automatic test_rows();
    for (int d = 0; d < 2; d++) begin
      wr_reg(8'h09, {d[0], 4'h0, 3'd2});
      pulse(3'b010);
      check(row, 0);
      for (int n = 1; n < 8; n++) begin
        pulse(3'b100);
        check(row, (d == 1) ? (n / 2) % 3 : n % 3);
      end
    end
    // enable low must freeze the row that the next line would advance
    ce = 1'b0;
    pulse(3'b100);
    ce = 1'b1;
    check(row, 0);
    $display("test rows done");
  endtask : test_rows

  task automatic frame(input int vb, input int cm, input logic [31:0] st);
    for (int k = 0; k < 6; k++) begin
      pulse((k == 0) ? 3'b010 : 3'b100);
      check(line, k);
      check(vblank, k >= vb);
      check(split, k >= cm);
      if (ext.mode[0] == 1'b0) begin
        check(start, st);
        check(mem, (k >= cm) ? 32'h0 : st);
      end
    end
  endtask : frame

  task automatic test_frames();
    ext.vbs_low = 8'h03;
    ext.cmp_low = 8'h02;
    ext.start_low = 8'h12;
    wr_reg(8'h0c, 8'h34);
    wr_reg(8'h09, 8'h00);
    frame(3, 2, 32'h3412);
    wr_reg(8'h09, 8'h60);
    frame(32'h203, 32'h202, 32'h3412);
    wr_reg(8'h09, 8'h00);
    ext.ovf = 8'h18;
    frame(32'h103, 32'h102, 32'h3412);
    // extended: the standard blanking high bits must stop mattering
    ext.mode = 8'h01;
    wr_reg(8'h09, 8'h60);
    frame(3, 32'h302, 32'h0);
    ext.vbs_ext = 8'h01;
    frame(32'h103, 32'h302, 32'h0);
    $display("test frames done");
  endtask : test_frames

  task automatic test_ext();
    logic [31:0] na;
    na = {8'h78, 6'h05, 8'h34, 8'h12, 2'b00};
    ext.ext_mid = 8'h05;
    ext.ext_top = 8'h78;
    pulse(3'b010);
    check(start, 32'h3412);
    ext.ext_mid = 8'h85;
    repeat (3) @(negedge clock_in);
    check(start, 32'h3412);
    tim.vsync = 1'b1;
    @(negedge clock_in);
    tim = '0;
    check(req_clr, 1'b1);
    check(start, na);
    @(negedge clock_in);
    check(req_clr, 1'b0);
    ext.ext_mid = 8'h05;
    @(negedge clock_in);
    check(mem, na);
    ext.mode = 8'h00;
    ext.ovf = 8'h00;
    $display("test ext done");
  endtask : test_ext

  task automatic test_cursor();
    wr_reg(8'h09, 8'h03);
    wr_reg(8'h0b, 8'h02);
    for (int m = 0; m < 3; m++) begin
      text = (m != 2);
      wr_reg(8'h0a, (m == 1) ? 8'h21 : 8'h01);
      pulse(3'b010);
      for (int r = 0; r < 4; r++) begin
        if (r > 0) pulse(3'b100);
        check(cursor, m == 0 && r >= 1 && r <= 2);
      end
    end
    text = 1'b1;
    pulse(3'b010);
    pulse(3'b100);
    for (int s = 0; s < 4; s++) begin
      wr_reg(8'h0b, {1'b0, s[1:0], 5'd2});
      hit = 1'b0;
      repeat (4) pulse(3'b001);
      hit = 1'b1;
      for (int k = 0; k < 4; k++) begin
        repeat (2) @(negedge clock_in);
        check(cursor, k >= s);
        pulse(3'b001);
      end
    end
    $display("test cursor done");
  endtask : test_cursor

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // whole run is about five hundred cycles, so this only trips on a hang
  initial begin
    repeat (20000) @(posedge clock_in);
    n_mismatch++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    repeat (10) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    test_regs();
    test_rows();
    test_frames();
    test_ext();
    test_cursor();
    summarize();
  end
endmodule : cscsr_bench
